// >>> isp_clk_div.v
/*
 Serial clock divider: pulses a one-cycle tick every half-period count while running.
 Assumes pclk domain; half period from a register of the same domain.
*/
`timescale 1ns/100ps
module isp_clk_div (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       run,
    input  wire [7:0] half_cnt,
    output reg        tick_r
);
    reg [7:0] cnt_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= 8'h00;
            tick_r <= 1'b0;
        end else if (!run) begin
            cnt_r  <= 8'h00;
            tick_r <= 1'b0;
        end else if (cnt_r + 8'h01 >= half_cnt) begin
            cnt_r  <= 8'h00;
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 8'h01;
            tick_r <= 1'b0;
        end
    end
endmodule

// >>> isp_consts.vh
/*
 Constants for the SPI master controller: register offsets, field positions, reset values and timing counts.
 Assumes inclusion by bare name from the controller's design files.
*/
`ifndef ISP_CONSTS_VH
`define ISP_CONSTS_VH

`define ISP_OFF_CTRL        8'h00
`define ISP_OFF_CMD         8'h04
`define ISP_OFF_WDATA       8'h08
`define ISP_OFF_RDATA       8'h0C
`define ISP_OFF_STATUS      8'h10
`define ISP_OFF_DIV         8'h14

`define ISP_CTRL_THREE_WIRE 0
`define ISP_CTRL_MODE3      1
`define ISP_CTRL_CS_SEL_LO  4
`define ISP_CTRL_CS_SEL_HI  5

`define ISP_CMD_ADDR_LO     0
`define ISP_CMD_ADDR_HI     6
`define ISP_CMD_READ        7
`define ISP_CMD_LEN_LO      8
`define ISP_CMD_LEN_HI      11

`define ISP_ST_BUSY         0
`define ISP_ST_DONE         1
`define ISP_ST_RVALID       2
`define ISP_ST_WNEED        3

`define ISP_CTRL_RST        32'h0000_0000
`define ISP_DIV_RST         8'h08
`define ISP_DIV_MIN         8'h05

`define ISP_ICTRL_ADDR      7'h00
`define ISP_ICTRL_3W_BIT    7
`define ISP_ICTRL_AI_BIT    6

`endif

// >>> isp_dev_model.sv
/* Behavioural sensor serial port: 128 byte registers, control register at address 0.
   Assumes one master; sees its own select only. */
`timescale 1ns/100ps
module isp_dev_model (
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic din4,
    input  wire logic din3,
    output wire logic dout
);
    logic [7:0] mem [0:127];
    logic [7:0] sh;
    logic [7:0] tx;
    logic [6:0] a;
    logic [3:0] bc;
    logic       hdr, rd, oe, last;
    wire        din = mem[0][7] ? din3 : din4;
    // Released line shows the inverse, so a stale bit never passes
    assign dout = oe ? last : ~last;
    initial begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'hA5 ^ i[7:0];
        mem[0] = 8'h00;
        {hdr, rd, oe, last, bc} = 8'h00;
        sh = 8'h00;
        tx = 8'h00;
        a = 7'h00;
    end
    always @(negedge cs_n) begin
        bc = 4'h0;
        hdr = 1'b1;
    end
    always @(posedge cs_n)
        oe = 1'b0;
    always @(posedge sclk) if (!cs_n) begin
        sh = {sh[6:0], din};
        bc = bc + 4'h1;
        if (bc == 4'h8) begin
            bc = 4'h0;
            if (hdr) begin
                {rd, a} = sh;
                hdr = 1'b0;
            end else if (!rd) begin
                mem[a] = sh;
                a = a + {6'h00, mem[0][6]};
            end
        end
    end
    always @(negedge sclk) if (!cs_n && !hdr && rd) begin
        if (bc == 4'h0) begin
            tx = mem[a];
            a = a + {6'h00, mem[0][6]};
        end
        last = tx[7];
        tx = tx << 1;
        oe = 1'b1;
    end
endmodule

// >>> isp_master.v
/*
 SPI master controller driving a motion sensor's serial port, with APB registers for software.
 Assumes an SPI slave per chip select on shared clock and data lines; APB in pclk domain.
*/
// Notes on behaviour
// R1: Four-wire uses select, clock, in and out lines; three-wire shares one data line.
// R2: Device turns its input pin into the shared data pin in three-wire form.
// R3: Device adapts to mode 0 or mode 3; master idles clock accordingly.
// R4: Device control bit 7 selects three-wire; reset value is four-wire.
// R5: Sample data on rising clock edge, change driven data on falling edge.
// R6: Every byte goes most significant bit first.
// R7: First byte is read flag then 7-bit address; 8-bit data bytes follow.
// R8: Single and burst transfers; burst length set by how long clocking continues.
// R9: Master holds chip select low from first address bit to last data bit.
// R10: Device steps address per burst byte when auto-increment bit 6 is set.
// R11: Auto-increment resets to 0; master should set it early for bursts.
// R12: Master must not burst-write configuration registers; single writes only.
// R13: Three-wire write: master drives all; read: master drives address only.
// R14: Shared clock and data, one separate chip select per device.
// R15: Device releases its data output while deselected or not sending.
// R16: Chip select active low; falling edge starts, rising edge ends a transfer.
`timescale 1ns/100ps
`include "isp_consts.vh"
module isp_master #(
    parameter NCS = 4
) (
    input  wire           pclk,
    input  wire           presetn,
    input  wire           psel,
    input  wire           penable,
    input  wire           pwrite,
    input  wire [7:0]     paddr,
    input  wire [31:0]    pwdata,
    output reg  [31:0]    prdata,
    output reg            pready,
    output reg            pslverr,
    output reg            serial_clock,
    output reg  [NCS-1:0] cs_n,
    output reg            mosi_o,
    output reg            sdio_oe,
    input  wire           serial_out_line,
    input  wire           sdio_i
);
    localparam S_IDLE = 5'b00001;
    localparam S_SETUP = 5'b00010;
    localparam S_LOW = 5'b00100;
    localparam S_HIGH = 5'b01000;
    localparam S_END = 5'b10000;

    reg  [31:0] ctrl_r;
    reg  [7:0]  div_r;
    reg  [7:0]  wdata_r;
    reg         wfull_r;
    reg  [7:0]  rdata_r;
    reg         rvalid_r;
    reg         done_r;
    reg  [4:0]  state_r;
    reg  [7:0]  sh_r;
    reg  [7:0]  rx_r;
    reg  [2:0]  bit_r;
    reg  [3:0]  left_r;
    reg         first_r;
    reg         rd_r;
    reg         three_r;
    reg         gap_r;
    reg         fresh_r;
    reg  [1:0]  cs_sel_r;
    wire        tick;
    wire [1:0]  pins_s;
    wire        run = (state_r != S_IDLE);
    wire        rx_bit = three_r ? pins_s[1] : pins_s[0]; // R1
    wire        acc = psel && penable;
    wire        busy = (state_r != S_IDLE);
    wire        wneed = !wfull_r && busy && !rd_r && (left_r != 4'd0);
    wire        cmd_cfg = !pwdata[`ISP_CMD_READ] && (pwdata[6:0] == `ISP_ICTRL_ADDR);

    function [NCS-1:0] cs_dec;
        input [1:0] sel;
        input       act;
        integer     i;
        begin
            cs_dec = {NCS{1'b1}};
            for (i = 0; i < NCS; i = i + 1) begin
                if (act && (sel == i[1:0])) begin
                    cs_dec[i] = 1'b0;
                end
            end
        end
    endfunction

    // Register decode shared by the write strobes and read clears
    function is_off;
        input [7:0] adr;
        input [7:0] off;
        begin
            is_off = (adr == off);
        end
    endfunction

    isp_sync #(
        .W(2)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({sdio_i, serial_out_line}),
        .dout_r  (pins_s)
    );

    isp_clk_div u_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (run),
        .half_cnt (div_r),
        .tick_r   (tick)
    );

    // APB slave, zero wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    `ISP_OFF_CTRL: begin
                        prdata <= ctrl_r;
                    end
                    `ISP_OFF_WDATA: begin
                        prdata <= {24'h00_0000, wdata_r};
                    end
                    `ISP_OFF_RDATA: begin
                        prdata <= {24'h00_0000, rdata_r};
                    end
                    `ISP_OFF_STATUS: begin
                        prdata <= {28'h000_0000, wneed, rvalid_r, done_r, busy};
                    end
                    `ISP_OFF_DIV: begin
                        prdata <= {24'h00_0000, div_r};
                    end
                    `ISP_OFF_CMD: begin
                        prdata <= 32'h0000_0000;
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    wire wr_acc = acc && pready && pwrite;
    wire rd_acc = acc && pready && !pwrite;
    wire wr_ctrl = wr_acc && is_off(paddr, `ISP_OFF_CTRL);
    wire wr_cmd = wr_acc && is_off(paddr, `ISP_OFF_CMD) && !busy;
    wire wr_wdata = wr_acc && is_off(paddr, `ISP_OFF_WDATA);
    wire wr_div = wr_acc && is_off(paddr, `ISP_OFF_DIV);
    wire rd_rdata = rd_acc && is_off(paddr, `ISP_OFF_RDATA);
    wire rd_status = rd_acc && is_off(paddr, `ISP_OFF_STATUS);
    wire byte_end = (state_r == S_HIGH) && tick && (bit_r == 3'd0);
    wire rx_store = byte_end && !first_r && rd_r;
    // Next write byte is taken at a byte boundary, or late while the clock is parked low
    wire load_tx = !rd_r && wfull_r && ((byte_end && (left_r != 4'd0)) || ((state_r == S_LOW) && gap_r));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `ISP_CTRL_RST;
            div_r  <= `ISP_DIV_RST;
        end else begin
            if (wr_ctrl && !busy) begin
                ctrl_r <= {26'h000_0000, pwdata[5:0]};
            end
            if (wr_div) begin
                div_r <= (pwdata[7:0] < `ISP_DIV_MIN) ? `ISP_DIV_MIN : pwdata[7:0];
            end
        end
    end

    // Serial engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r      <= S_IDLE;
            serial_clock <= 1'b0;
            cs_n         <= {NCS{1'b1}};
            mosi_o       <= 1'b0;
            sdio_oe      <= 1'b0;
            sh_r         <= 8'h00;
            rx_r         <= 8'h00;
            bit_r        <= 3'd7;
            left_r       <= 4'd0;
            first_r      <= 1'b0;
            rd_r         <= 1'b0;
            three_r      <= 1'b0;
            gap_r        <= 1'b0;
            fresh_r      <= 1'b0;
            cs_sel_r     <= 2'd0;
            wdata_r      <= 8'h00;
            wfull_r      <= 1'b0;
            rdata_r      <= 8'h00;
            rvalid_r     <= 1'b0;
            done_r       <= 1'b0;
        end else begin
            if (wr_wdata) begin
                wdata_r <= pwdata[7:0];
                wfull_r <= 1'b1;
            end else if (load_tx) begin
                wfull_r <= 1'b0;
            end
            // A byte stored at the setup edge was not the one returned, so it stays valid
            fresh_r <= rx_store;
            if (rd_rdata && !rx_store && !fresh_r) begin
                rvalid_r <= 1'b0;
            end
            // Only a done flag that the read actually returned is cleared
            if (rd_status && prdata[`ISP_ST_DONE] && !(state_r == S_END && tick)) begin
                done_r <= 1'b0;
            end
            case (state_r)
                S_IDLE: begin
                    serial_clock <= ctrl_r[`ISP_CTRL_MODE3]; // R3
                    sdio_oe      <= 1'b0;
                    if (wr_cmd) begin
                        three_r  <= ctrl_r[`ISP_CTRL_THREE_WIRE];
                        gap_r    <= 1'b0;
                        cs_sel_r <= ctrl_r[`ISP_CTRL_CS_SEL_HI:`ISP_CTRL_CS_SEL_LO];
                        rd_r     <= pwdata[`ISP_CMD_READ];
                        sh_r     <= pwdata[7:0]; // R7
                        // Device control registers take single writes only
                        if (cmd_cfg && (pwdata[11:8] > 4'd1)) begin
                            left_r <= 4'd1; // R12
                        end else begin
                            left_r <= pwdata[`ISP_CMD_LEN_HI:`ISP_CMD_LEN_LO]; // R8
                        end
                        first_r  <= 1'b1;
                        bit_r    <= 3'd7;
                        state_r  <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    cs_n    <= cs_dec(cs_sel_r, 1'b1); // R16 R14
                    mosi_o  <= sh_r[7]; // R6
                    sdio_oe <= 1'b1;
                    if (tick) begin
                        state_r      <= S_LOW;
                        serial_clock <= 1'b0;
                    end
                end
                S_LOW: begin
                    // A stalled write holds the clock low with select kept asserted
                    if (gap_r) begin
                        if (wfull_r) begin
                            sh_r   <= wdata_r;
                            mosi_o <= wdata_r[7]; // R6
                            gap_r  <= 1'b0;
                        end
                    end else if (tick) begin
                        serial_clock <= 1'b1;
                        rx_r         <= {rx_r[6:0], rx_bit}; // R5
                        state_r      <= S_HIGH;
                    end
                end
                S_HIGH: begin
                    if (tick) begin
                        serial_clock <= 1'b0; // R5
                        if (bit_r != 3'd0) begin
                            bit_r   <= bit_r - 3'd1;
                            sh_r    <= {sh_r[6:0], 1'b0};
                            mosi_o  <= sh_r[6]; // R6
                            state_r <= S_LOW;
                        end else begin
                            bit_r <= 3'd7;
                            if (!first_r && rd_r) begin
                                rdata_r  <= rx_r;
                                rvalid_r <= 1'b1;
                            end
                            if (left_r == 4'd0) begin
                                state_r <= S_END;
                                sdio_oe <= 1'b0;
                            end else begin
                                left_r  <= left_r - 4'd1;
                                first_r <= 1'b0;
                                state_r <= S_LOW;
                                if (rd_r) begin
                                    sdio_oe <= 1'b0; // R13
                                    mosi_o  <= 1'b0;
                                end else begin
                                    sdio_oe <= 1'b1; // R13
                                    if (wfull_r) begin
                                        sh_r   <= wdata_r;
                                        mosi_o <= wdata_r[7];
                                    end else begin
                                        gap_r <= 1'b1;
                                    end
                                end
                            end
                        end
                    end
                end
                S_END: begin
                    // Idle level returns only after select is high, so no extra sample edge
                    if (tick) begin
                        cs_n    <= {NCS{1'b1}}; // R9 R16
                        done_r  <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> isp_master_asserts.sv
/* Port checker for the SPI master controller.
   Assumes binding to isp_master; all signals in the pclk domain. */
`timescale 1ns/100ps
module isp_master_asserts #(
    parameter NCS = 4
) (
    input wire logic           pclk,
    input wire logic           presetn,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pready,
    input wire logic           pslverr,
    input wire logic           serial_clock,
    input wire logic [NCS-1:0] cs_n,
    input wire logic           mosi_o,
    input wire logic           sdio_oe
);
    logic [7:0] nrise_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Rising link edges in the current frame; idle mode switches never count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            nrise_r <= 8'h00;
        else if (&cs_n)
            nrise_r <= 8'h00;
        else if ($rose(serial_clock))
            nrise_r <= nrise_r + 8'h01;
    end
    sequence s_high5;
        serial_clock [*5];
    endsequence
    sequence s_no_rise4;
        !$rose(serial_clock) [*4];
    endsequence
    AST_APB_ZERO_WAIT: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_ONE_SELECT: assert property ($onehot0(~cs_n))
        else $error("more than one select low");
    AST_DATA_AT_RISE: assert property ($rose(serial_clock) |-> $stable(mosi_o))
        else $error("data changed at rising link edge");
    AST_WHOLE_BYTES: assert property ($rose(&cs_n) |-> nrise_r != 8'h00 && nrise_r[2:0] == 3'h0)
        else $error("frame ended inside a byte");
    AST_SETUP_GAP: assert property ($fell(&cs_n) |-> s_no_rise4)
        else $error("link edge too soon after select");
    AST_HALF_PERIOD: assert property ($rose(serial_clock) |-> s_high5)
        else $error("link clock high phase too short");
    AST_RELEASE_IDLE: assert property ((&cs_n) [*2] |-> !sdio_oe)
        else $error("data line driven while idle");
endmodule
bind isp_master isp_master_asserts #(.NCS(NCS)) u_isp_master_asserts (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .serial_clock(serial_clock),
    .cs_n(cs_n), .mosi_o(mosi_o), .sdio_oe(sdio_oe));

// >>> isp_master_tb_top.sv
/* Self-checking bench for the SPI master controller, device model on select 0.
   Assumes the controller's APB map from its constants header. */
`timescale 1ns/100ps
`include "isp_consts.vh"
module isp_master_tb_top;
    localparam logic [31:0] Z = 32'h0000_0000;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = Z;
    logic [31:0] prdata, q;
    logic        pready, pslverr, serial_clock, mosi_o, sdio_oe, dout, err;
    logic [3:0]  cs_n;
    logic [7:0]  got [0:3];
    wire         sdio_line = sdio_oe ? mosi_o : dout;
    int          n_mismatch = 0, compares = 0, cyc = 0;
    always #4 pclk = ~pclk;
    isp_master #(.NCS(4)) u_isp_master (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_clock(serial_clock), .cs_n(cs_n), .mosi_o(mosi_o), .sdio_oe(sdio_oe),
        .serial_out_line(dout), .sdio_i(sdio_line));
    isp_dev_model u_isp_dev_model (.cs_n(cs_n[0]), .sclk(serial_clock), .din4(mosi_o), .din3(sdio_line),
        .dout(dout));
    task test_done;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Done clears on read, so each wait polls one status bit only
    task poll(input int b);
        int t;
        t = 0;
        do begin
            apb(1'b0, `ISP_OFF_STATUS, Z);
            t++;
        end while (q[b] !== 1'b1 && t < 400);
        if (t >= 400)
            chk(8'h00, 8'h01);
    endtask
    task cmd(input logic r, input logic [6:0] a, input logic [3:0] n);
        apb(1'b1, `ISP_OFF_CMD, {20'h0_0000, n, r, a});
    endtask
    task dwr(input logic [6:0] a, input logic [7:0] d);
        apb(1'b1, `ISP_OFF_WDATA, {24'h00_0000, d});
        cmd(1'b0, a, 4'h1);
        poll(`ISP_ST_DONE);
    endtask
    task brd(input logic [6:0] a, input logic [3:0] n);
        cmd(1'b1, a, n);
        for (int i = 0; i < n; i++) begin
            poll(`ISP_ST_RVALID);
            apb(1'b0, `ISP_OFF_RDATA, Z);
            got[i] = q[7:0];
        end
        poll(`ISP_ST_DONE);
    endtask
    task t_regs;
        apb(1'b0, `ISP_OFF_CTRL, Z);
        chk(q[7:0], 8'h00);
        apb(1'b0, `ISP_OFF_DIV, Z);
        chk(q[7:0], `ISP_DIV_RST);
        apb(1'b0, 8'h40, Z);
        chk({7'h00, err}, 8'h01);
        $display("t_regs done");
    endtask
    task t_single;
        brd(7'h00, 4'h1);
        chk(got[0], 8'h00);
        dwr(7'h20, 8'h3C);
        brd(7'h20, 4'h1);
        chk(got[0], 8'h3C);
        $display("t_single done");
    endtask
    task t_burst;
        apb(1'b1, `ISP_OFF_CTRL, 32'h0000_0002);
        dwr(7'h00, 8'h40);
        apb(1'b1, `ISP_OFF_WDATA, 32'h0000_0011);
        cmd(1'b0, 7'h30, 4'h2);
        apb(1'b0, `ISP_OFF_STATUS, Z);
        chk({7'h00, q[`ISP_ST_BUSY]}, 8'h01);
        poll(`ISP_ST_WNEED);
        apb(1'b1, `ISP_OFF_WDATA, 32'h0000_0022);
        poll(`ISP_ST_DONE);
        brd(7'h30, 4'h3);
        chk(got[0], 8'h11);
        chk(got[1], 8'h22);
        chk(got[2], 8'h97);
        dwr(7'h00, 8'h00);
        brd(7'h30, 4'h2);
        chk(got[0], 8'h11);
        chk(got[1], 8'h11);
        $display("t_burst done");
    endtask
    task t_three;
        apb(1'b1, `ISP_OFF_CTRL, Z);
        dwr(7'h00, 8'h80);
        apb(1'b1, `ISP_OFF_CTRL, 32'h0000_0001);
        dwr(7'h21, 8'h96);
        brd(7'h21, 4'h1);
        chk(got[0], 8'h96);
        $display("t_three done");
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            test_done;
        end
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_single;
        t_burst;
        t_three;
        test_done;
    end
endmodule

// >>> isp_sync.v
/*
 Two-flop synchroniser for link input pins.
 Assumes asynchronous input to the pclk domain.
*/
`timescale 1ns/100ps
module isp_sync #(
    parameter W = 2
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout_r
);
    reg [W-1:0] meta_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= {W{1'b0}};
            dout_r <= {W{1'b0}};
        end else begin
            meta_r <= din;
            dout_r <= meta_r;
        end
    end
endmodule
